// File: rtl/bdsc_bridge_ctrl.sv
// Purpose: state control of a full-bridge transformer driver
// Assumes: strap resistances arrive as digitised ohm values
// Notes:   AHB-Lite slave, zero wait states, always OKAY
// What this block does
// - bypass: stop switching on UVLO or faults
// - loss of sync when high/low time doubles
// - loss of sync when period exceeds maximum
// - faults drive ready low, outputs tri-state
// - restart in bypass after faults or UVLO
// - rate strap selects one of 41 frequencies
// - duty strap selects 10 to 50 percent
// - overcurrent strap decodes into five levels
// - nine operating states incl. bypass sync
// - below UVLO stay off, outputs tri-state
// - past UVLO enter config read, tri-state
// - config read samples pins, latches setting
// - bypass locks to three external PWM cycles
// - sync measurement sets precharge enable
// - self-test checks shorts, fault if found
// - self-test toggles outputs driven and tri-state
// - fault state holds until faults clear
// - after fault wait, then self-test
// - precharge only below 45 percent duty
// - soft start done: ready high, run
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`include "bdsc_defines.svh"
module bdsc_bridge_ctrl #(
	parameter logic [15:0] MAX_PERIOD_CYC =
		16'(`BDSC_MAX_PERIOD_NS / `BDSC_CLK_PERIOD_NS),
	parameter logic [22:0] PRECHG_TMO_CYC =
		23'(`BDSC_PRECHG_TMO_NS / `BDSC_CLK_PERIOD_NS)
) (
	// clock and reset
	input  logic        SYS_CLK,
	input  logic        RST,
	// ahb-lite slave
	input  logic        HSEL,
	input  logic [31:0] HADDR,
	input  logic [1:0]  HTRANS,
	input  logic        HWRITE,
	input  logic [2:0]  HSIZE,
	input  logic [31:0] HWDATA,
	input  logic        HREADY,
	output logic [31:0] HRDATA,
	output logic        HREADYOUT,
	output logic        HRESP,
	// supply, pins and straps
	input  logic        SUPPLY_OK,
	input  logic        RATE_SELECT_PIN,
	input  logic        DUTY_SELECT_PIN,
	input  logic [15:0] RATE_STRAP_OHM,
	input  logic [15:0] DUTY_STRAP_OHM,
	input  logic [15:0] OC_STRAP_OHM,
	// analog monitors
	input  logic        AVG_OC_FAULT,
	input  logic        PEAK_OC_FAULT,
	input  logic        OVERTEMP_FAULT,
	input  logic        SHORT_TO_SUPPLY,
	input  logic        SHORT_TO_GND,
	input  logic        PRECHARGE_DONE,
	input  logic        SOFTSTART_DONE,
	// bridge and ready
	output logic        BRIDGE_OUTPUT_A,
	output logic        BRIDGE_OUTPUT_A_OE,
	output logic        BRIDGE_OUTPUT_B,
	output logic        BRIDGE_OUTPUT_B_OE,
	output logic        READY
);
	import bdsc_pkg::*;

	// ****************************************
	// strap tables
	// ****************************************
	localparam logic [15:0] RES [41] = '{
		16'd332, 16'd412, 16'd499, 16'd590, 16'd698, 16'd806, 16'd931,
		16'd1070, 16'd1210, 16'd1370, 16'd1540, 16'd1740, 16'd1960,
		16'd2210, 16'd2490, 16'd2800, 16'd3160, 16'd3480, 16'd3920,
		16'd4320, 16'd4750, 16'd5760, 16'd6980, 16'd8250, 16'd9530,
		16'd11000, 16'd12700, 16'd14700, 16'd16500, 16'd18700,
		16'd21000, 16'd23700, 16'd26700, 16'd30100, 16'd34000,
		16'd38300, 16'd42200, 16'd47500, 16'd52300, 16'd57600,
		16'd63400};
	localparam int FREQ_KHZ [41] = '{
		50, 53, 57, 61, 65, 70, 74, 79, 85, 90, 97, 103, 110, 118,
		126, 134, 143, 153, 163, 175, 186, 199, 213, 227, 243, 259,
		277, 295, 316, 337, 360, 384, 410, 438, 468, 500, 534, 570,
		609, 651, 695};

	logic [39:0] rate_above, duty_above, oc_above;
	logic [11:0] per_tab [41];

	genvar gi;
	generate
		for (gi = 0; gi < 41; gi++) begin : g_tab
			// nearest table value wins: count midpoints below the strap
			if (gi < 40) begin : g_mid
				localparam int MID =
					(int'(RES[gi]) + int'(RES[gi + 1])) / 2;
				assign rate_above[gi] = RATE_STRAP_OHM > 16'(MID);
				assign duty_above[gi] = DUTY_STRAP_OHM > 16'(MID);
				assign oc_above[gi]   = OC_STRAP_OHM > 16'(MID);
			end
			assign per_tab[gi] = 12'(`BDSC_CLK_KHZ / FREQ_KHZ[gi]);
		end
	endgenerate

	function automatic bdsc_idx_type count_ones(input logic [39:0] v);
		bdsc_idx_type n;
		n = '0;
		for (int k = 0; k < 40; k++)
			n = n + bdsc_idx_type'(v[k]);
		return n;
	endfunction

	bdsc_idx_type rate_idx, duty_idx, oc_idx;
	logic [2:0]   oc_lvl;
	assign rate_idx = count_ones(rate_above);
	assign duty_idx = count_ones(duty_above);
	assign oc_idx   = count_ones(oc_above);

	always_comb begin
		if (oc_idx <= 6'h07)
			oc_lvl = 3'h1;
		else if (oc_idx <= 6'h0f)
			oc_lvl = 3'h2;
		else if (oc_idx <= 6'h17)
			oc_lvl = 3'h3;
		else if (oc_idx <= 6'h1f)
			oc_lvl = 3'h4;
		else
			oc_lvl = 3'h5;
	end

	// ****************************************
	// register bus
	// ****************************************
	logic        ctrl_en_q;
	logic [15:0] wait_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        addr_ok;
	logic [31:0] rd_d;

	assign addr_ok = HSEL & HTRANS[1] & HREADY;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok & HWRITE;
			wr_addr_q <= HADDR[7:0];
		end
	end

	// software enable gates leaving the off state; wait sets the hold-off
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_en_q <= 1'(`BDSC_CTRL_RESET);
			wait_q    <= `BDSC_WAIT_RESET;
		end else if (wr_pend_q) begin
			if (wr_addr_q == `BDSC_ADDR_CTRL)
				ctrl_en_q <= HWDATA[0];
			if (wr_addr_q == `BDSC_ADDR_WAIT)
				wait_q <= HWDATA[15:0];
		end
	end

	// ****************************************
	// state and configuration
	// ****************************************
	bdsc_state_type state_q, state_d;
	bdsc_idx_type   rate_q, duty_q;
	logic [2:0]     oc_q;
	logic           bypass_q, pre_en_q, los_q;
	logic [11:0]    per_q, hi_q, ph_q;
	logic [22:0]    tmr_q;
	logic [15:0]    meas_hi_q, meas_per_q;
	logic           any_fault, short_seen, los_now, sync_done;
	logic           pin_q, pin_p;
	logic [15:0]    run_q, last_hi_q, last_lo_q;
	logic [2:0]     sync_cnt_q;
	logic           rise, fall, dbl_hi, dbl_lo, too_long;

	assign any_fault = AVG_OC_FAULT | PEAK_OC_FAULT | OVERTEMP_FAULT;
	assign short_seen = SHORT_TO_SUPPLY | SHORT_TO_GND;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (ctrl_en_q)
					state_d = ST_CFG;
			ST_CFG:
				state_d = DUTY_SELECT_PIN ? ST_SELF : ST_SYNC;
			ST_SYNC:
				if (sync_done)
					state_d = ST_SELF;
			ST_SELF:
				if (short_seen)
					state_d = ST_FAULT;
				else if (tmr_q == `BDSC_SELF_TEST_CYC - 23'h1)
					state_d = pre_en_q ? ST_PRE : ST_SOFT;
			ST_PRE:
				if (any_fault || tmr_q == PRECHG_TMO_CYC - 23'h1)
					state_d = ST_FAULT;
				else if (PRECHARGE_DONE)
					state_d = ST_SOFT;
			ST_SOFT:
				if (any_fault)
					state_d = ST_FAULT;
				else if (SOFTSTART_DONE)
					state_d = ST_RUN;
			ST_RUN:
				if (any_fault || los_now)
					state_d = ST_FAULT;
			ST_FAULT:
				if (!any_fault)
					state_d = ST_WAIT;
			ST_WAIT:
				if (any_fault)
					state_d = ST_FAULT;
				else if (tmr_q[15:0] >= wait_q)
					state_d = ST_SELF;
			default:
				state_d = ST_OFF;
		endcase
		if (!SUPPLY_OK)
			state_d = ST_OFF;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_q <= ST_OFF;
			tmr_q   <= '0;
		end else begin
			state_q <= state_d;
			tmr_q   <= (state_d != state_q) ? 23'h0 : tmr_q + 23'h1;
		end
	end

	// configuration latched once per power-up
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rate_q   <= '0;
			duty_q   <= '0;
			oc_q     <= 3'h1;
			bypass_q <= 1'b0;
			pre_en_q <= 1'b0;
			per_q    <= 12'h0;
			hi_q     <= 12'h0;
		end else if (state_q == ST_CFG) begin
			rate_q   <= rate_idx;
			duty_q   <= duty_idx;
			oc_q     <= oc_lvl;
			bypass_q <= ~DUTY_SELECT_PIN;
			per_q    <= per_tab[rate_idx];
			hi_q     <= 12'((20'(per_tab[rate_idx]) *
				(20'(duty_idx) + 20'(`BDSC_DUTY_BASE_PCT))) / 20'd100);
			pre_en_q <= (7'(duty_idx) + `BDSC_DUTY_BASE_PCT) <
				`BDSC_PRECHG_DUTY_PCT;
		end else if (sync_done) begin
			// measured duty decides precharge in bypass
			pre_en_q <= 23'(meas_hi_q) * 23'd100 <
				23'(16'(meas_hi_q + run_q)) *
				23'(`BDSC_PRECHG_DUTY_PCT);
		end
	end

	// ****************************************
	// external pwm measurement
	// ****************************************
	assign rise = pin_q & ~pin_p;
	assign fall = ~pin_q & pin_p;
	assign dbl_hi = fall && last_hi_q != 16'h0 &&
		17'(run_q) > (17'(last_hi_q) << `BDSC_LOS_FACTOR_SH);
	assign dbl_lo = rise && last_lo_q != 16'h0 &&
		17'(run_q) > (17'(last_lo_q) << `BDSC_LOS_FACTOR_SH);
	// a stuck pin also runs past the longest period
	assign too_long = (rise && 17'(last_hi_q) + 17'(run_q) >
		17'(MAX_PERIOD_CYC)) || run_q > MAX_PERIOD_CYC;
	assign los_now = bypass_q && state_q == ST_RUN &&
		(dbl_hi || dbl_lo || too_long);
	assign sync_done = state_q == ST_SYNC && rise &&
		sync_cnt_q == `BDSC_SYNC_CYCLES;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pin_q     <= 1'b0;
			pin_p     <= 1'b0;
			run_q     <= 16'h0;
			last_hi_q <= 16'h0;
			last_lo_q <= 16'h0;
		end else begin
			pin_q <= RATE_SELECT_PIN;
			pin_p <= pin_q;
			// saturating count keeps a stalled pin from wrapping
			if (rise || fall)
				run_q <= 16'h1;
			else if (run_q != 16'hffff)
				run_q <= run_q + 16'h1;
			if (fall)
				last_hi_q <= run_q;
			if (rise)
				last_lo_q <= run_q;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sync_cnt_q <= 3'h0;
			meas_hi_q  <= 16'h0;
			meas_per_q <= 16'h0;
		end else if (state_q != ST_SYNC) begin
			sync_cnt_q <= 3'h0;
		end else if (rise) begin
			sync_cnt_q <= sync_cnt_q + 3'h1;
			meas_hi_q  <= last_hi_q;
			meas_per_q <= 16'(last_hi_q + run_q);
		end
	end

	// sticky loss flag, kept until the wait state
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			los_q <= 1'b0;
		else if (los_now)
			los_q <= 1'b1;
		else if (state_q == ST_WAIT)
			los_q <= 1'b0;
	end

	// ****************************************
	// bridge drive
	// ****************************************
	logic a_d, a_oe_d, b_d, b_oe_d, pwm_a, pwm_b;
	logic [11:0] half;

	assign half  = per_q >> 1;
	assign pwm_a = ph_q < hi_q;
	assign pwm_b = ph_q >= half && ph_q < half + hi_q;

	always_ff @(posedge SYS_CLK) begin
		if (RST || ph_q + 12'h1 >= per_q)
			ph_q <= 12'h0;
		else
			ph_q <= ph_q + 12'h1;
	end

	always_comb begin
		a_d    = 1'b0;
		b_d    = 1'b0;
		a_oe_d = 1'b0;
		b_oe_d = 1'b0;
		case (state_d)
			ST_SELF: begin
				a_oe_d = tmr_q[0];
				b_oe_d = tmr_q[0];
				a_d    = tmr_q < (`BDSC_SELF_TEST_CYC >> 1);
				b_d    = ~a_d;
			end
			ST_PRE: begin
				a_oe_d = 1'b1;
				b_oe_d = 1'b1;
				b_d    = 1'b1;
			end
			ST_SOFT: begin
				a_oe_d = 1'b1;
				b_oe_d = 1'b1;
				a_d    = pwm_a;
				b_d    = pwm_b;
			end
			ST_RUN: begin
				a_oe_d = 1'b1;
				b_oe_d = 1'b1;
				a_d    = bypass_q ? pin_q : pwm_a;
				b_d    = bypass_q ? ~pin_q : pwm_b;
			end
			default: ;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			BRIDGE_OUTPUT_A    <= 1'b0;
			BRIDGE_OUTPUT_A_OE <= 1'b0;
			BRIDGE_OUTPUT_B    <= 1'b0;
			BRIDGE_OUTPUT_B_OE <= 1'b0;
			READY              <= 1'b0;
		end else begin
			BRIDGE_OUTPUT_A    <= a_d;
			BRIDGE_OUTPUT_A_OE <= a_oe_d;
			BRIDGE_OUTPUT_B    <= b_d;
			BRIDGE_OUTPUT_B_OE <= b_oe_d;
			READY              <= state_d == ST_RUN;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		case (HADDR[7:0])
			`BDSC_ADDR_CTRL:   rd_d = {31'h0, ctrl_en_q};
			`BDSC_ADDR_STATUS: rd_d = {21'h0, los_q, SHORT_TO_GND,
				SHORT_TO_SUPPLY, OVERTEMP_FAULT, PEAK_OC_FAULT,
				AVG_OC_FAULT, READY, state_q};
			`BDSC_ADDR_CONFIG: rd_d = {15'h0, pre_en_q, bypass_q, oc_q,
				duty_q, rate_q};
			`BDSC_ADDR_MEAS:   rd_d = {meas_per_q, meas_hi_q};
			`BDSC_ADDR_WAIT:   rd_d = {16'h0, wait_q};
			default:           rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			HRDATA    <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			if (addr_ok && !HWRITE)
				HRDATA <= rd_d;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

endmodule // bdsc_bridge_ctrl

// File: rtl/bdsc_defines.svh
// Purpose: offsets, reset values and timing figures of the bridge control
// Assumes: 200 MHz system clock
// Notes:   definitions only
`ifndef BDSC_DEFINES_SVH
`define BDSC_DEFINES_SVH
// ****************************************
// register map
// ****************************************
`define BDSC_ADDR_CTRL    8'h00
`define BDSC_ADDR_STATUS  8'h04
`define BDSC_ADDR_CONFIG  8'h08
`define BDSC_ADDR_MEAS    8'h0c
`define BDSC_ADDR_WAIT    8'h10
`define BDSC_CTRL_RESET   32'h0000_0001
`define BDSC_WAIT_RESET   16'h0400
// ****************************************
// timing
// ****************************************
`define BDSC_CLK_PERIOD_NS   5
`define BDSC_CLK_KHZ         200000
`define BDSC_MAX_PERIOD_NS   22500
`define BDSC_PRECHG_TMO_NS   20000000
`define BDSC_SYNC_CYCLES     3'h3
`define BDSC_SELF_TEST_CYC   23'h10
`define BDSC_LOS_FACTOR_SH   1
`define BDSC_PRECHG_DUTY_PCT 7'h2d
`define BDSC_DUTY_BASE_PCT   7'h0a
`endif

// File: rtl/bdsc_pkg.sv
// Purpose: types shared by the bridge control
// Assumes: nothing
// Notes:   state codes follow declaration order, 0 to 8
package bdsc_pkg;
	typedef enum logic [3:0] {
		ST_OFF, ST_CFG, ST_SYNC, ST_SELF, ST_PRE,
		ST_SOFT, ST_RUN, ST_FAULT, ST_WAIT
	} bdsc_state_type;
	typedef logic [5:0] bdsc_idx_type;
endpackage

// File: sim/bdsc_bridge_ctrl_chk.sv
// Purpose: port checks of the bridge control
// Assumes: one clock, sync reset high
// Notes:   bound from the bench top
module bdsc_bridge_ctrl_chk #(
	parameter logic [15:0] MAX_PERIOD_CYC = 16'h1194
) (
	// clock and reset
	input logic        SYS_CLK,
	input logic        RST,
	// watched ports
	input logic        HREADYOUT,
	input logic        HRESP,
	input logic        SUPPLY_OK,
	input logic        RATE_SELECT_PIN,
	input logic        DUTY_SELECT_PIN,
	input logic        AVG_OC_FAULT,
	input logic        PEAK_OC_FAULT,
	input logic        OVERTEMP_FAULT,
	input logic        SOFTSTART_DONE,
	input logic        BRIDGE_OUTPUT_A_OE,
	input logic        BRIDGE_OUTPUT_B_OE,
	input logic        READY
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        pin_q;
	logic        byp_q;
	logic [15:0] stuck_q;
	logic        flt;
	logic        tri_rdy_lo;
	assign flt = AVG_OC_FAULT | PEAK_OC_FAULT | OVERTEMP_FAULT;
	assign tri_rdy_lo = !READY && !BRIDGE_OUTPUT_A_OE && !BRIDGE_OUTPUT_B_OE;
	// cycles since the external pwm last moved
	always_ff @(posedge SYS_CLK) begin
		pin_q <= RATE_SELECT_PIN;
		if (RST || RATE_SELECT_PIN != pin_q)
			stuck_q <= 16'h0;
		else if (stuck_q != 16'hffff)
			stuck_q <= stuck_q + 16'h1;
	end
	// mode is frozen once supply is up, as the device latches it
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			byp_q <= 1'b0;
		else if (!SUPPLY_OK)
			byp_q <= !DUTY_SELECT_PIN;
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	property p_rst; $fell(RST) |-> tri_rdy_lo; endproperty
	a_rst: assert property (p_rst)
		else $error("outputs live after reset");
	property p_off; !SUPPLY_OK |=> tri_rdy_lo; endproperty
	a_off: assert property (p_off)
		else $error("outputs live without supply");
	property p_cfg; $rose(SUPPLY_OK) |=> tri_rdy_lo; endproperty
	a_cfg: assert property (p_cfg)
		else $error("outputs live in config read");
	property p_flt; READY && flt |=> tri_rdy_lo; endproperty
	a_flt: assert property (p_flt)
		else $error("fault did not stop the bridge");
	property p_hold; !READY && SUPPLY_OK && flt |=> !READY; endproperty
	a_hold: assert property (p_hold)
		else $error("ready rose while faulted");
	property p_rise;
		$rose(READY) |-> $past(SOFTSTART_DONE) && $past(SUPPLY_OK);
	endproperty
	a_rise: assert property (p_rise)
		else $error("ready rose without soft start end");
	property p_los;
		byp_q && stuck_q == MAX_PERIOD_CYC + 16'h10 |-> !READY;
	endproperty
	a_los: assert property (p_los)
		else $error("stuck pwm not flagged");
	property p_bus; HREADYOUT && !HRESP; endproperty
	a_bus: assert property (p_bus)
		else $error("bus answer not ready and okay");
endmodule // bdsc_bridge_ctrl_chk

// File: sim/bdsc_bridge_ctrl_tb_top.sv
// Purpose: self-checking bench of the bridge control
// Assumes: 200 MHz clock, zero wait bus
// Notes:   fault wait shortened by register write
`define CHK(w, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", w, e, g); end end
module bdsc_bridge_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, hsel, hwrite, hrdy, hresp, sup, dpin, pin;
	logic        s_gnd, pwm_en, a, aoe, b, boe, rdy, pcd, ssd;
	logic [1:0]  htrans;
	logic [2:0]  flt;
	logic [15:0] r_ohm, d_ohm, o_ohm, p_hi, p_lo;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          n_fail, tests_run;
	bdsc_bridge_ctrl #(.PRECHG_TMO_CYC(23'hc8)) bdsc_bridge_ctrl_inst (
		.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
		.SUPPLY_OK(sup), .RATE_SELECT_PIN(pin), .DUTY_SELECT_PIN(dpin),
		.RATE_STRAP_OHM(r_ohm), .DUTY_STRAP_OHM(d_ohm),
		.OC_STRAP_OHM(o_ohm), .AVG_OC_FAULT(flt[0]),
		.PEAK_OC_FAULT(flt[1]), .OVERTEMP_FAULT(flt[2]),
		.SHORT_TO_SUPPLY(1'b0), .SHORT_TO_GND(s_gnd),
		.PRECHARGE_DONE(pcd), .SOFTSTART_DONE(ssd),
		.BRIDGE_OUTPUT_A(a), .BRIDGE_OUTPUT_A_OE(aoe),
		.BRIDGE_OUTPUT_B(b), .BRIDGE_OUTPUT_B_OE(boe), .READY(rdy));
	bdsc_pwm_src bdsc_pwm_src_inst (.clk(clk), .en(pwm_en),
		.hi_cyc(p_hi), .lo_cyc(p_lo), .pin(pin));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task wait_rdy(input logic v);
		int k;
		k = 0;
		while (rdy !== v && k < 30000) begin
			@(negedge clk);
			k++;
		end
		`CHK("ready", v, rdy)
		`CHK("oe", {v, v}, {aoe, boe})
		@(posedge clk);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		close_out;
	end
	initial begin
		{n_fail, tests_run} = '0;
		{hsel, hwrite, htrans, haddr, hwdata, sup, s_gnd, flt} = '0;
		{rst, dpin, pwm_en} = 3'h6;
		{pcd, ssd} = 2'h0;
		r_ohm = 16'hf7a8;
		d_ohm = 16'h014c;
		o_ohm = 16'h684c;
		p_hi = 16'h012c;
		p_lo = 16'h02bc;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(0, 8'h00, 0); `CHK("ctrl", 32'h1, rd)
		ahb(0, 8'h10, 0); `CHK("wait", 32'h400, rd)
		ahb(1, 8'h20, 32'hffff_ffff);
		ahb(0, 8'h20, 0); `CHK("hole", 32'h0, rd)
		ahb(1, 8'h10, 32'h8);
		ahb(0, 8'h04, 0); `CHK("off", 4'h0, rd[3:0])
		$display("test registers done");
		sup <= 1'b1;
		repeat (40) @(posedge clk);
		ahb(0, 8'h04, 0); `CHK("pre", 5'h04, rd[4:0])
		`CHK("pre_pins", 4'hd, {aoe, boe, a, b})
		pcd <= 1'b1;
		repeat (4) @(posedge clk);
		ahb(0, 8'h04, 0); `CHK("soft", 5'h05, rd[4:0])
		ssd <= 1'b1;
		wait_rdy(1'b1);
		ahb(0, 8'h08, 0); `CHK("cfg", 32'h0001_5028, rd)
		ahb(0, 8'h04, 0); `CHK("run", 5'h16, rd[4:0])
		$display("test start done");
		for (int i = 0; i < 3; i++) begin
			flt <= 3'h1 << i;
			wait_rdy(1'b0);
			ahb(0, 8'h04, 0); `CHK("fault", 4'h7, rd[3:0])
			flt <= 3'h0;
			wait_rdy(1'b1);
		end
		s_gnd <= 1'b1;
		flt <= 3'h1;
		wait_rdy(1'b0);
		flt <= 3'h0;
		repeat (200) @(posedge clk);
		`CHK("short", 1'b0, rdy)
		s_gnd <= 1'b0;
		wait_rdy(1'b1);
		$display("test faults done");
		sup <= 1'b0;
		dpin <= 1'b0;
		o_ohm <= 16'h0c58;
		pwm_en <= 1'b1;
		@(posedge clk);
		ahb(0, 8'h04, 0); `CHK("uvlo", 4'h0, rd[3:0])
		sup <= 1'b1;
		wait_rdy(1'b1);
		ahb(0, 8'h08, 0); `CHK("byp", 5'h1b, rd[16:12])
		ahb(0, 8'h0c, 0); `CHK("meas", 32'h03e8_012c, rd)
		p_lo <= 16'h05dc;
		wait_rdy(1'b0);
		ahb(0, 8'h04, 0); `CHK("los", 1'b1, rd[10])
		p_lo <= 16'h02bc;
		wait_rdy(1'b1);
		pwm_en <= 1'b0;
		wait_rdy(1'b0);
		pwm_en <= 1'b1;
		wait_rdy(1'b1);
		$display("test bypass done");
		close_out;
	end
endmodule // bdsc_bridge_ctrl_tb_top
bind bdsc_bridge_ctrl bdsc_bridge_ctrl_chk #(
	.MAX_PERIOD_CYC(MAX_PERIOD_CYC)) bdsc_bridge_ctrl_chk_inst (
	.SYS_CLK(SYS_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.SUPPLY_OK(SUPPLY_OK), .RATE_SELECT_PIN(RATE_SELECT_PIN),
	.DUTY_SELECT_PIN(DUTY_SELECT_PIN), .AVG_OC_FAULT(AVG_OC_FAULT),
	.PEAK_OC_FAULT(PEAK_OC_FAULT), .OVERTEMP_FAULT(OVERTEMP_FAULT),
	.SOFTSTART_DONE(SOFTSTART_DONE), .BRIDGE_OUTPUT_A_OE(BRIDGE_OUTPUT_A_OE),
	.BRIDGE_OUTPUT_B_OE(BRIDGE_OUTPUT_B_OE), .READY(READY));

// File: sim/bdsc_pwm_src.sv
// Purpose: external pwm source in front of the rate select pin
// Assumes: counts in system clock cycles
// Notes:   disabling it leaves the pin stuck, which is a sync loss
module bdsc_pwm_src (
	input logic        clk,
	input logic        en,
	input logic [15:0] hi_cyc,
	input logic [15:0] lo_cyc,
	output logic       pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_q;
	initial begin
		pin = 1'b0;
		cnt_q = 16'h0;
	end
	// high time stays well above the minimum on time
	always @(posedge clk) begin
		if (en) begin
			cnt_q <= cnt_q + 16'h1;
			if (cnt_q + 16'h1 >= (pin ? hi_cyc : lo_cyc)) begin
				pin <= ~pin;
				cnt_q <= 16'h0;
			end
		end
	end
endmodule // bdsc_pwm_src
